// ===== design/lic_pkg.sv
/*
  Package for the line interface control and status register group:
  register indices, field positions, reset values and line modes.
  Assumes APB byte addresses are four times the register index.
*/
package lic_pkg;

  // register indices; byte address is index * 4
  localparam logic [5:0] LIC_IDX_RX_LEVEL = 6'h11;
  localparam logic [5:0] LIC_IDX_STATUS = 6'h14;
  localparam logic [5:0] LIC_IDX_MASK = 6'h15;
  localparam logic [5:0] LIC_IDX_JA_CTRL = 6'h31;
  localparam logic [5:0] LIC_IDX_GAIN_CODE = 6'h32;
  localparam logic [5:0] LIC_IDX_TERM_PRESC = 6'h33;
  localparam logic [5:0] LIC_IDX_MODE = 6'h3F;

  // gain_boost_and_line_code_ctrl fields
  localparam int LIC_POS_GAIN = 3;
  localparam int LIC_POS_CMI_INV = 6;
  localparam int LIC_POS_CMI_ON = 7;
  localparam logic [7:0] LIC_GAIN_CODE_WMASK = 8'hD8;

  // termination_and_prescale_ctrl fields
  localparam int LIC_POS_RX_TERM = 0;
  localparam int LIC_POS_TX_TERM = 3;
  localparam int LIC_POS_PRESC = 6;

  // jitter clock source control field
  localparam int LIC_POS_JA_SRC = 3;
  localparam logic [7:0] LIC_JA_CTRL_WMASK = 8'h08;

  // status and mask bit positions
  localparam int LIC_POS_TOC = 1;
  localparam int LIC_POS_TCL = 2;
  localparam int LIC_POS_JAL = 4;
  localparam logic [7:0] LIC_FLAG_WMASK = 8'h16;

  localparam logic [7:0] LIC_RST_CTRL = 8'h00;
  localparam logic [1:0] LIC_RST_MODE = 2'h0;

  // terminations, one-hot: bit0 75, bit1 100, bit2 120, bit3 110 ohm
  localparam logic [3:0] LIC_TERM_NONE = 4'h0;

  typedef enum logic [1:0] {
    LIC_MODE_T1,
    LIC_MODE_E1,
    LIC_MODE_CC64,
    LIC_MODE_6312
  } lic_mode_t;

  // master clock figures in kHz
  localparam logic [14:0] LIC_MCLK_T1_BASE = 15'h0608;
  localparam logic [14:0] LIC_MCLK_E1_BASE = 15'h0800;

endpackage

// ===== design/lic_regs.sv
/*
  Control and status register group of a T1/E1 line interface, reached over APB.
  Assumes raw line conditions and receive level come from the analog side,
  asynchronous to pclk; control outputs steer the analog line front end.
*/
// Register access over APB was decided locally.
// Notes on behaviour
// R01: gain field selects 0/20/26/32 dB boost
// R02: polarity bit inverts CMI both directions
// R03: line-code bit turns CMI coding on
// R04: software writes zero to bits 1,2,5
// R05: receive termination code map, others disabled
// R06: transmit termination same map, bits 3-5
// R07: T1 prescaler clock set follows jitter source
// R08: E1 prescaler codes give 2.048 to 16.384
// R09: receive level reported live in 2.5 dB
// R10: open-circuit flag live, not 6312 mode
// R11: current-limit flag live, not CMI/64k/6312
// R12: near-limit event sets sticky flag
// R13: status read clears near-limit flag
// R14: attenuator event only in T1, E1
// R15: mask one interrupts on both condition edges
// R16: near-limit mask bit enables its interrupt
// R17: software keeps unused flag bits zero
// R18: jitter clock source prescaled clock or PLL
// R19: low transmit termination bits zero for HRL
// R20: interrupt held while unmasked event pending
// R21: read back as written, unused bits zero
`timescale 1ns/1ps

module lic_regs
  import lic_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_open_circuit_in,
  input wire logic tx_current_limit_in,
  input wire logic jitter_near_limit_in,
  input wire logic [3:0] rx_level_in,
  output logic [1:0] monitor_gain_sel,
  output logic line_code_cmi_on,
  output logic tx_cmi_invert,
  output logic rx_cmi_invert,
  output logic [3:0] rx_term_en,
  output logic [3:0] tx_term_en,
  output logic [1:0] master_clk_prescale,
  output logic [14:0] mclk_expect_khz,
  output logic jitter_clk_from_pll,
  output logic jitter_atten_active,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  logic [5:0] idx;
  logic acc;
  logic wr;
  logic rd;
  logic mapped;
  assign idx = paddr[7:2];
  assign acc = psel && penable;
  assign pready = 1'b1;
  assign wr = acc && pwrite && pstrb[0] && mapped;
  assign rd = acc && !pwrite;

  always_comb begin
    case (idx)
      LIC_IDX_RX_LEVEL, LIC_IDX_STATUS, LIC_IDX_MASK, LIC_IDX_JA_CTRL,
      LIC_IDX_GAIN_CODE, LIC_IDX_TERM_PRESC, LIC_IDX_MODE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = acc && !mapped;

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  logic [7:0] gain_code_r;
  logic [7:0] term_presc_r;
  logic [7:0] ja_ctrl_r;
  logic [7:0] mask_r;
  lic_mode_t mode_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_code_r <= LIC_RST_CTRL;
      term_presc_r <= LIC_RST_CTRL;
      ja_ctrl_r <= LIC_RST_CTRL;
      mask_r <= LIC_RST_CTRL;
      mode_r <= lic_mode_t'(LIC_RST_MODE);
    end else if (wr) begin
      // unused bits are not stored, so they read back zero [R21] [R04] [R17]
      case (idx)
        LIC_IDX_GAIN_CODE: gain_code_r <= pwdata[7:0] & LIC_GAIN_CODE_WMASK;
        LIC_IDX_TERM_PRESC: term_presc_r <= pwdata[7:0];
        LIC_IDX_JA_CTRL: ja_ctrl_r <= pwdata[7:0] & LIC_JA_CTRL_WMASK;
        LIC_IDX_MASK: mask_r <= pwdata[7:0] & LIC_FLAG_WMASK;
        LIC_IDX_MODE: mode_r <= lic_mode_t'(pwdata[1:0]);
        default: mode_r <= mode_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control outputs

  function automatic logic [3:0] term_decode(input logic [2:0] code);
    case (code)
      3'h1: term_decode = 4'h1;
      3'h2: term_decode = 4'h2;
      3'h3: term_decode = 4'h4;
      3'h4: term_decode = 4'h8;
      default: term_decode = LIC_TERM_NONE;
    endcase
  endfunction

  logic cmi_inv;
  logic ja_src;
  logic [1:0] presc;

  assign cmi_inv = gain_code_r[LIC_POS_CMI_INV];
  assign ja_src = ja_ctrl_r[LIC_POS_JA_SRC];
  assign presc = term_presc_r[LIC_POS_PRESC +: 2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      monitor_gain_sel <= 2'h0;
      line_code_cmi_on <= 1'b0;
      tx_cmi_invert <= 1'b0;
      rx_cmi_invert <= 1'b0;
      rx_term_en <= LIC_TERM_NONE;
      tx_term_en <= LIC_TERM_NONE;
      master_clk_prescale <= 2'h0;
      mclk_expect_khz <= LIC_MCLK_T1_BASE;
      jitter_clk_from_pll <= 1'b0;
      jitter_atten_active <= 1'b0;
    end else begin
      monitor_gain_sel <= gain_code_r[LIC_POS_GAIN +: 2]; // [R01]
      line_code_cmi_on <= gain_code_r[LIC_POS_CMI_ON]; // [R03]
      tx_cmi_invert <= cmi_inv; // [R02]
      rx_cmi_invert <= cmi_inv; // [R02]
      rx_term_en <= term_decode(term_presc_r[LIC_POS_RX_TERM +: 3]); // [R05]
      tx_term_en <= term_decode(term_presc_r[LIC_POS_TX_TERM +: 3]); // [R06] [R19]
      master_clk_prescale <= presc;
      // T1 base clock follows the jitter clock source; E1 always 2.048 [R07] [R08]
      if (mode_r == LIC_MODE_T1 && !ja_src) begin
        mclk_expect_khz <= LIC_MCLK_T1_BASE << presc; // [R07]
      end else begin
        mclk_expect_khz <= LIC_MCLK_E1_BASE << presc; // [R08]
      end
      jitter_clk_from_pll <= ja_src && mode_r == LIC_MODE_T1; // [R18]
      jitter_atten_active <= mode_r == LIC_MODE_T1 || mode_r == LIC_MODE_E1; // [R14]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: a change counts once stages two and three agree

  localparam int NSYNC = 7;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync_q;

  assign raw_in = {rx_level_in, jitter_near_limit_in, tx_current_limit_in,
                   tx_open_circuit_in};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      logic s1_r;
      logic s2_r;
      logic s3_r;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          s1_r <= raw_in[gi];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            sync_q[gi] <= s3_r;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // status conditions and events

  logic toc_cond;
  logic tcl_cond;
  logic jal_in;
  logic jal_prev_r;
  logic toc_prev_r;
  logic tcl_prev_r;
  logic jal_r;
  logic toc_pend_r;
  logic tcl_pend_r;
  logic [3:0] rx_level_r;
  logic sr_read;
  logic jal_set;

  assign toc_cond = sync_q[0] && mode_r != LIC_MODE_6312; // [R10]
  assign tcl_cond = sync_q[1] && !gain_code_r[LIC_POS_CMI_ON] // [R11]
                    && mode_r != LIC_MODE_CC64 && mode_r != LIC_MODE_6312;
  assign jal_in = sync_q[2] && jitter_atten_active; // [R14]
  assign sr_read = rd && idx == LIC_IDX_STATUS;
  assign jal_set = jal_in && !jal_prev_r; // [R12]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_level_r <= 4'h0;
    end else begin
      rx_level_r <= sync_q[6:3]; // [R09]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jal_prev_r <= 1'b0;
      toc_prev_r <= 1'b0;
      tcl_prev_r <= 1'b0;
    end else begin
      jal_prev_r <= jal_in;
      toc_prev_r <= toc_cond;
      tcl_prev_r <= tcl_cond;
    end
  end

  // sticky near-limit event; a new event beats the read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jal_r <= 1'b0;
    end else if (jal_set) begin
      jal_r <= 1'b1; // [R12]
    end else if (sr_read) begin
      jal_r <= 1'b0; // [R13]
    end
  end

  // either edge of a condition latches a pending interrupt, cleared by status read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      toc_pend_r <= 1'b0;
      tcl_pend_r <= 1'b0;
    end else begin
      if (toc_cond != toc_prev_r) begin
        toc_pend_r <= 1'b1; // [R15]
      end else if (sr_read) begin
        toc_pend_r <= 1'b0;
      end
      if (tcl_cond != tcl_prev_r) begin
        tcl_pend_r <= 1'b1; // [R15]
      end else if (sr_read) begin
        tcl_pend_r <= 1'b0;
      end
    end
  end

  logic irq_nxt;
  assign irq_nxt = (toc_pend_r && mask_r[LIC_POS_TOC]) // [R15]
                   || (tcl_pend_r && mask_r[LIC_POS_TCL]) // [R15]
                   || (jal_r && mask_r[LIC_POS_JAL]); // [R16]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_nxt; // [R20]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data

  logic [7:0] status_byte;
  always_comb begin
    status_byte = 8'h00;
    status_byte[LIC_POS_TOC] = toc_cond;
    status_byte[LIC_POS_TCL] = tcl_cond;
    status_byte[LIC_POS_JAL] = jal_r;
  end

  always_comb begin
    prdata = 32'h0000_0000;
    case (idx)
      LIC_IDX_RX_LEVEL: prdata[3:0] = rx_level_r; // [R09] [R21]
      LIC_IDX_STATUS: prdata[7:0] = status_byte;
      LIC_IDX_MASK: prdata[7:0] = mask_r;
      LIC_IDX_JA_CTRL: prdata[7:0] = ja_ctrl_r;
      LIC_IDX_GAIN_CODE: prdata[7:0] = gain_code_r; // [R21]
      LIC_IDX_TERM_PRESC: prdata[7:0] = term_presc_r;
      LIC_IDX_MODE: prdata[1:0] = mode_r;
      default: prdata = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_gain;
    @(posedge pclk) disable iff (!presetn)
      (wr && idx == LIC_IDX_GAIN_CODE) |-> ##2 monitor_gain_sel == $past(pwdata[4:3], 2);
  endproperty
  a_gain: assert property (p_gain) else $error("gain select not applied"); // [R01]

  property p_cmi;
    @(posedge pclk) disable iff (!presetn)
      (wr && idx == LIC_IDX_GAIN_CODE) |-> ##2 (tx_cmi_invert == $past(pwdata[6], 2)
        && rx_cmi_invert == $past(pwdata[6], 2) && line_code_cmi_on == $past(pwdata[7], 2));
  endproperty
  a_cmi: assert property (p_cmi) else $error("cmi controls wrong"); // [R02]

  property p_term;
    @(posedge pclk) disable iff (!presetn)
      (wr && idx == LIC_IDX_TERM_PRESC && pwdata[2:0] > 3'h4) |-> ##2
        rx_term_en == LIC_TERM_NONE;
  endproperty
  a_term: assert property (p_term) else $error("rx termination not off"); // [R05]

  property p_mclk;
    @(posedge pclk) disable iff (!presetn)
      (mode_r == LIC_MODE_E1 && presc == 2'h3) [*2] |-> mclk_expect_khz == 15'h4000;
  endproperty
  a_mclk: assert property (p_mclk) else $error("e1 master clock wrong"); // [R08]

  property p_toc;
    @(posedge pclk) disable iff (!presetn)
      (sr_read && mode_r == LIC_MODE_6312) |-> !prdata[LIC_POS_TOC];
  endproperty
  a_toc: assert property (p_toc) else $error("open flag in 6312 mode"); // [R10]

  property p_jal_set;
    @(posedge pclk) disable iff (!presetn)
      $rose(sync_q[2]) && jitter_atten_active |-> ##[1:2] jal_r;
  endproperty
  a_jal_set: assert property (p_jal_set) else $error("near-limit not latched"); // [R12]

  property p_jal_clr;
    @(posedge pclk) disable iff (!presetn)
      (sr_read && !jal_set) |=> !jal_r;
  endproperty
  a_jal_clr: assert property (p_jal_clr) else $error("read did not clear"); // [R13]

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
      (jal_r && mask_r[LIC_POS_JAL]) [*2] |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("pending event lost irq"); // [R20]

  property p_unused;
    @(posedge pclk) disable iff (!presetn)
      (rd && idx == LIC_IDX_STATUS) |-> (prdata[7:0] & ~LIC_FLAG_WMASK) == 8'h00;
  endproperty
  a_unused: assert property (p_unused) else $error("unused status bits set"); // [R21]

endmodule

// ===== testbench/lic_regs_tb.sv
/*
  Self-checking testbench for lic_regs: APB tasks and directed register,
  line-status and interrupt sequences.
  Assumes lic_pkg is compiled first and a single 200 MHz clock.
*/
`timescale 1ns/1ps

module lic_regs_tb
  import lic_pkg::*;
;
  localparam logic [7:0] A_LVL = {LIC_IDX_RX_LEVEL, 2'b00};
  localparam logic [7:0] A_STAT = {LIC_IDX_STATUS, 2'b00};
  localparam logic [7:0] A_MASK = {LIC_IDX_MASK, 2'b00};
  localparam logic [7:0] A_JA = {LIC_IDX_JA_CTRL, 2'b00};
  localparam logic [7:0] A_GAIN = {LIC_IDX_GAIN_CODE, 2'b00};
  localparam logic [7:0] A_TERM = {LIC_IDX_TERM_PRESC, 2'b00};
  localparam logic [7:0] A_MODE = {LIC_IDX_MODE, 2'b00};

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat, e;
  logic [3:0] pstrb, rx_level_in, rx_term_en, tx_term_en;
  logic [2:0] cond;
  logic [1:0] monitor_gain_sel, master_clk_prescale;
  logic line_code_cmi_on, tx_cmi_invert, rx_cmi_invert;
  logic jitter_clk_from_pll, jitter_atten_active, irq;
  logic [14:0] mclk_expect_khz;
  int n_errors, checks;

  lic_regs DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_open_circuit_in(cond[0]), .tx_current_limit_in(cond[1]),
    .jitter_near_limit_in(cond[2]), .rx_level_in(rx_level_in),
    .monitor_gain_sel(monitor_gain_sel), .line_code_cmi_on(line_code_cmi_on),
    .tx_cmi_invert(tx_cmi_invert), .rx_cmi_invert(rx_cmi_invert),
    .rx_term_en(rx_term_en), .tx_term_en(tx_term_en),
    .master_clk_prescale(master_clk_prescale), .mclk_expect_khz(mclk_expect_khz),
    .jitter_clk_from_pll(jitter_clk_from_pll),
    .jitter_atten_active(jitter_atten_active), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic end_sim;
    if (n_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // one APB transfer; request held until pready is sampled high, for at most 20 cycles
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) chk(0, 1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rdat, exp);
    chk(rerr, 0);
  endtask

  function automatic logic [3:0] term_exp(input int c);
    case (c)
      1: term_exp = 4'h1;
      2: term_exp = 4'h2;
      3: term_exp = 4'h4;
      4: term_exp = 4'h8;
      default: term_exp = 4'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    end_sim;
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, cond, rx_level_in} = '0;
    pstrb = 4'hF;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    tick(4);
    chk(mclk_expect_khz, 15'h0608);
    chk(irq, 0);
    rd(A_STAT, 0);
    rd(A_MASK, 0);
    rd(A_GAIN, 0);
    rd(A_TERM, 0);
    // refused accesses: unmapped index and cleared byte strobe
    xfer(1'b1, 8'h04, 32'h0000_00FF);
    xfer(1'b0, 8'h04, 32'h0);
    chk(rdat, 0);
    chk(rerr, 1);
    pstrb <= 4'h0;
    wr(A_GAIN, 32'h0000_0080);
    pstrb <= 4'hF;
    rd(A_GAIN, 0);
    for (int g = 0; g < 4; g++) begin
      e = 32'({g[0], g[1], 1'b0, 2'(g), 3'b000});
      wr(A_GAIN, e);
      tick(2);
      chk(monitor_gain_sel, g);
      chk(line_code_cmi_on, g[0]);
      chk(tx_cmi_invert, g[1]);
      chk(rx_cmi_invert, g[1]);
      rd(A_GAIN, e);
    end
    for (int c = 0; c < 8; c++) begin
      e = 32'({2'b00, 3'(7 - c), 3'(c)});
      wr(A_TERM, e);
      tick(2);
      chk(rx_term_en, term_exp(c));
      chk(tx_term_en, term_exp(7 - c));
      rd(A_TERM, e);
    end
    for (int k = 0; k < 16; k++) begin
      wr(A_MODE, k[3]);
      wr(A_JA, 32'(k[2]) << 3);
      wr(A_TERM, 32'(k[1:0]) << 6);
      tick(2);
      e = (k[3:2] == 2'b00) ? 32'h0608 << k[1:0] : 32'h0800 << k[1:0];
      chk(master_clk_prescale, k[1:0]);
      chk(mclk_expect_khz, e);
      chk(jitter_clk_from_pll, k[3:2] == 2'b01);
      rd(A_JA, 32'(k[2]) << 3);
    end
    for (int v = 0; v < 16; v++) begin
      @(posedge pclk);
      rx_level_in <= 4'(v);
      tick(8);
      rd(A_LVL, v);
    end
    wr(A_GAIN, 0);
    for (int m = 0; m < 4; m++) begin
      wr(A_MODE, m);
      @(posedge pclk);
      cond <= 3'b011;
      tick(8);
      e = {27'h0, 1'b0, 1'b0, m < 2, m != 3, 1'b0};
      rd(A_STAT, e);
      chk(jitter_atten_active, m < 2);
      @(posedge pclk);
      cond[2] <= 1'b1;
      repeat (2) @(posedge pclk);
      cond[2] <= 1'b0;
      tick(8);
      rd(A_STAT, e | (32'(m < 2) << 4));
      rd(A_STAT, e);
      @(posedge pclk);
      cond <= 3'b000;
      tick(8);
    end
    wr(A_MODE, 0);
    wr(A_GAIN, 32'h0000_0080);
    @(posedge pclk);
    cond <= 3'b011;
    tick(8);
    rd(A_STAT, 32'h02);
    wr(A_GAIN, 0);
    @(posedge pclk);
    cond <= 3'b000;
    tick(8);
    xfer(1'b0, A_STAT, 0);
    // masked condition edge must stay silent
    @(posedge pclk);
    cond[0] <= 1'b1;
    tick(8);
    chk(irq, 0);
    @(posedge pclk);
    cond[0] <= 1'b0;
    tick(8);
    xfer(1'b0, A_STAT, 0);
    for (int i = 0; i < 3; i++) begin
      e = (i == 2) ? 32'h10 : 32'h2 << i;
      wr(A_MASK, e);
      rd(A_MASK, e);
      @(posedge pclk);
      cond[i] <= 1'b1;
      tick(8);
      chk(irq, 1);
      xfer(1'b0, A_STAT, 0);
      tick(2);
      chk(irq, 0);
      @(posedge pclk);
      cond[i] <= 1'b0;
      tick(8);
      chk(irq, i != 2);
      wr(A_MASK, 0);
      tick(2);
      chk(irq, 0);
      xfer(1'b0, A_STAT, 0);
    end
    end_sim;
  end
endmodule
